// ### chs_params.svh
// Timing and encoding constants for the channel service scheduler.
// Assumes inclusion by bare name from the scheduler package and module.
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH

// Slot transition, new-round no-op, and stall per parameter memory collision
`define CHS_TRANS_CLKS 5'h0a
`define CHS_NOP_CLKS 5'h04
`define CHS_STALL_CLKS 6'h02
// Edge-driven pulse-width service state lengths
`define CHS_PWM_RISE_CLKS 5'h18
`define CHS_PWM_FALL_CLKS 5'h02
// Slot pattern length and last slot index
`define CHS_SLOTS 3'h7
`define CHS_LAST_SLOT 3'h6
// Priority level codes
`define CHS_PRIO_OFF 2'h0
`define CHS_PRIO_LOW 2'h1
`define CHS_PRIO_MID 2'h2
`define CHS_PRIO_HIGH 2'h3

`endif

// ### chs_pkg.sv
// Types shared by the channel service scheduler.
// Assumes chs_params.svh is on the include path.
`include "chs_params.svh"

package chs_pkg;
  // Scheduler sequencing states
  typedef enum logic [1:0] {
    CHS_PICK,
    CHS_NOP,
    CHS_SERVE,
    CHS_TRANS
  } chs_state_e;

  // Priority level of a channel or slot
  typedef logic [1:0] chs_prio_t;
endpackage : chs_pkg

// ### chs_scheduler.sv
// Channel service scheduler: grants one microengine to requesting timer channels.
// Assumes all inputs synchronous to sys_clk; the engine holds svc_done until grant drops.
//
// Notes on behaviour
// - Slots follow H-M-H-L-H-M-H, repeating back to back.
// - Ten-clock transition follows every serviced time slot.
// - Four-clock no-op when a level restarts round.
// - Each memory collision stalls service two clocks.
// - Pulse-width channels request at every pin edge.
// - Service after rise 24 clocks, after fall 2.
`timescale 1ns/10ps
`include "chs_params.svh"

module chs_scheduler #(
  parameter int NCH = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [NCH-1:0] svc_req,
  input wire logic [2*NCH-1:0] chan_prio,
  input wire logic [NCH-1:0] chan_is_pwm,
  input wire logic [NCH-1:0] pwm_pin,
  input wire logic ram_collision,
  input wire logic svc_done,
  output logic grant_valid,
  output logic [$clog2(NCH)-1:0] grant_chan,
  output chs_pkg::chs_prio_t slot_prio,
  output logic nop_active,
  output logic trans_active,
  output logic stall_active
);
  import chs_pkg::*;

  localparam int CW = $clog2(NCH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  chs_state_e state_reg, state_next;
  logic [2:0] slot_reg, slot_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [5:0] stall_reg, stall_next;
  logic [CW-1:0] chan_reg, chan_next;
  logic pwm_svc_reg, pwm_svc_next;
  logic [NCH-1:0] sgl_reg, sgl_next;
  logic [NCH-1:0] pwm_evt_reg, pwm_evt_next;
  logic [NCH-1:0] pwm_rose_reg, pwm_rose_next;
  logic [NCH-1:0] pin_prev_reg, pin_prev_next;
  logic [NCH-1:0] pend, at_lvl, cand, edge_hit;
  logic [CW-1:0] pick;
  chs_prio_t cur_prio;
  logic work, finish;

  // Slot pattern lookup
  function automatic chs_prio_t slot_level(input logic [2:0] idx);
    chs_prio_t p;
    case (idx)
      3'h1, 3'h5: p = `CHS_PRIO_MID;
      3'h3: p = `CHS_PRIO_LOW;
      default: p = `CHS_PRIO_HIGH;
    endcase
    return p;
  endfunction : slot_level

  // ----------------------------------------------------------------
  // Request decode and candidate selection
  // ----------------------------------------------------------------
  always_comb begin
    cur_prio = slot_level(slot_reg);
    edge_hit = chan_is_pwm & (pwm_pin ^ pin_prev_reg);
    pend = svc_req | pwm_evt_reg;
    for (int i = 0; i < NCH; i++) begin
      at_lvl[i] = (chan_prio[2*i +: 2] == cur_prio);
    end
    cand = pend & at_lvl & ~sgl_reg;
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick = CW'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    cnt_next = cnt_reg;
    stall_next = stall_reg;
    chan_next = chan_reg;
    pwm_svc_next = pwm_svc_reg;
    sgl_next = sgl_reg;
    pwm_evt_next = pwm_evt_reg;
    pwm_rose_next = pwm_rose_reg;
    pin_prev_next = pwm_pin;
    work = 1'b0;
    finish = 1'b0;
    case (state_reg)
      CHS_PICK: begin
        if (|cand) begin
          chan_next = pick;
          pwm_svc_next = pwm_evt_reg[pick];
          cnt_next = pwm_rose_reg[pick] ? `CHS_PWM_RISE_CLKS : `CHS_PWM_FALL_CLKS;
          stall_next = '0;
          state_next = CHS_SERVE;
        end else if (|(pend & at_lvl)) begin
          sgl_next = sgl_reg & ~at_lvl;
          cnt_next = `CHS_NOP_CLKS;
          state_next = CHS_NOP;
        end else begin
          // Nothing wanted at this level: pass the slot on after this one pick clock, with no transition or no-op
          slot_next = (slot_reg == `CHS_LAST_SLOT) ? 3'h0 : slot_reg + 3'h1;
        end
      end
      CHS_NOP: begin
        cnt_next = cnt_reg - 5'h01;
        if (cnt_reg == 5'h01) begin
          state_next = CHS_PICK;
        end
      end
      CHS_SERVE: begin
        // Work advances only when no stall is owed; a collision on the last
        // work cycle holds it so the two stall clocks are still paid
        work = (stall_reg == 6'h00)
               && !(ram_collision && (pwm_svc_reg ? (cnt_reg == 5'h01) : svc_done));
        stall_next = stall_reg - ((stall_reg != 6'h00) ? 6'h01 : 6'h00)
                     + (ram_collision ? `CHS_STALL_CLKS : 6'h00);
        if (pwm_svc_reg) begin
          finish = work && (cnt_reg == 5'h01);
          if (work) begin
            cnt_next = cnt_reg - 5'h01;
          end
        end else begin
          finish = work && svc_done;
        end
        if (finish) begin
          sgl_next[chan_reg] = 1'b1;
          pwm_evt_next[chan_reg] = 1'b0;
          cnt_next = `CHS_TRANS_CLKS;
          state_next = CHS_TRANS;
        end
      end
      default: begin
        cnt_next = cnt_reg - 5'h01;
        if (cnt_reg == 5'h01) begin
          slot_next = (slot_reg == `CHS_LAST_SLOT) ? 3'h0 : slot_reg + 3'h1;
          state_next = CHS_PICK;
        end
      end
    endcase
    // A new pin edge wins over the clear at service end
    pwm_evt_next = pwm_evt_next | edge_hit;
    for (int i = 0; i < NCH; i++) begin
      if (edge_hit[i]) begin
        pwm_rose_next[i] = pwm_pin[i];
      end
    end
  end

  // Sequencing registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CHS_PICK;
      slot_reg <= 3'h0;
      cnt_reg <= 5'h00;
      stall_reg <= 6'h00;
      chan_reg <= '0;
      pwm_svc_reg <= 1'b0;
      sgl_reg <= '0;
      pwm_evt_reg <= '0;
      pwm_rose_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      cnt_reg <= cnt_next;
      stall_reg <= stall_next;
      chan_reg <= chan_next;
      pwm_svc_reg <= pwm_svc_next;
      sgl_reg <= sgl_next;
      pwm_evt_reg <= pwm_evt_next;
      pwm_rose_reg <= pwm_rose_next;
      pin_prev_reg <= pin_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_valid <= 1'b0;
      grant_chan <= '0;
      slot_prio <= `CHS_PRIO_HIGH;
      nop_active <= 1'b0;
      trans_active <= 1'b0;
      stall_active <= 1'b0;
    end else begin
      grant_valid <= (state_next == CHS_SERVE);
      grant_chan <= chan_next;
      slot_prio <= slot_level(slot_next);
      nop_active <= (state_next == CHS_NOP);
      trans_active <= (state_next == CHS_TRANS);
      stall_active <= (state_next == CHS_SERVE) && (stall_next != 6'h00);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Run length of the current state, work cycles in service, pin level at pick
  logic [5:0] run_reg, work_run_reg;
  logic rose_at_pick_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= 6'h00;
      work_run_reg <= 6'h00;
      rose_at_pick_reg <= 1'b0;
    end else begin
      run_reg <= (state_next != state_reg) ? 6'h00 : run_reg + 6'h01;
      work_run_reg <= (state_reg != CHS_SERVE) ? 6'h00 : work_run_reg + {5'h00, work};
      if (state_reg == CHS_PICK && cand != '0) begin
        rose_at_pick_reg <= pin_prev_reg[pick];
      end
    end
  end

  sequence leave_trans;
    state_reg == CHS_TRANS && state_next != CHS_TRANS;
  endsequence
  sequence leave_nop;
    state_reg == CHS_NOP && state_next != CHS_NOP;
  endsequence

  chk_slot_order: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slot_reg != $past(slot_reg) |-> slot_reg == (($past(slot_reg) == `CHS_LAST_SLOT) ? 3'h0
                                                 : $past(slot_reg) + 3'h1))
    else $error("slot pattern skipped or reordered");
  chk_trans_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    leave_trans |-> run_reg + 6'h01 == {1'b0, `CHS_TRANS_CLKS} ##1 state_reg == CHS_PICK)
    else $error("slot transition not ten clocks");
  chk_nop_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    leave_nop |-> run_reg + 6'h01 == {1'b0, `CHS_NOP_CLKS} ##1 state_reg == CHS_PICK)
    else $error("no-op not four clocks");
  chk_nop_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == CHS_PICK ##1 state_reg == CHS_NOP |-> (sgl_reg & $past(at_lvl)) == '0)
    else $error("no-op entered without clearing level latches");
  chk_stall_add: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == CHS_SERVE && ram_collision && !finish |=>
      stall_reg == $past(stall_reg) + 6'h02 - (($past(stall_reg) != 6'h00) ? 6'h01 : 6'h00))
    else $error("collision did not add two stall clocks");
  chk_pwm_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
    edge_hit != '0 |=> (pwm_evt_reg & $past(edge_hit)) == $past(edge_hit))
    else $error("pin edge did not raise a request");
  chk_pwm_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    finish && pwm_svc_reg |-> work_run_reg + 6'h01 ==
      (rose_at_pick_reg ? {1'b0, `CHS_PWM_RISE_CLKS} : {1'b0, `CHS_PWM_FALL_CLKS}))
    else $error("edge service length wrong");
  chk_lowest_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == CHS_PICK && cand != '0 |=>
      grant_valid && (($past(cand) >> grant_chan) & NCH'(1)) == NCH'(1)
      && ($past(cand) & ((NCH'(1) << grant_chan) - NCH'(1))) == '0)
    else $error("grant not to lowest unserved channel");
endmodule : chs_scheduler

// ### chs_channel_model.sv
// Behavioural model of the engine side that serves granted timer channels.
// Assumes one sys_clk domain and the scheduler's grant outputs as inputs.
`timescale 1ns/10ps

module chs_channel_model #(
  parameter int NCH = 16,
  parameter int DLY = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic grant_valid,
  input wire logic [$clog2(NCH)-1:0] grant_chan,
  input wire logic [NCH-1:0] chan_is_pwm,
  output logic svc_done
);
  int cnt;

  // Finish non-pwm service after DLY+1 granted cycles, hold done until the grant drops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      svc_done <= 1'b0;
    end else if (grant_valid && !chan_is_pwm[grant_chan]) begin
      cnt <= cnt + 1;
      svc_done <= (cnt >= DLY);
    end else begin
      cnt <= 0;
      svc_done <= 1'b0;
    end
  end
endmodule : chs_channel_model

// ### chs_scheduler_tb_top.sv
// Self-checking bench for the channel service scheduler.
// Assumes chs_pkg, chs_scheduler and chs_channel_model are compiled first.
`timescale 1ns/10ps

module chs_scheduler_tb_top;
  import chs_pkg::*;
  typedef struct {int chan; int len; int nop; int stall;} chs_note_s;
  logic sys_clk, reset_n, ram_collision, svc_done;
  logic grant_valid, nop_active, trans_active, stall_active;
  logic [15:0] svc_req, chan_is_pwm, pwm_pin;
  logic [31:0] chan_prio, rnd;
  logic [3:0] grant_chan;
  chs_prio_t slot_prio;
  chs_note_s q[$];
  chs_note_s cur;
  int pat[9] = '{1, 2, 1, 4, 1, 2, 1, 1, 2};
  int miscompares, n_checks, glen, stl, trn, nops, i, k, t;
  bit ing, prev;

  chs_scheduler dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .svc_req(svc_req),
    .chan_prio(chan_prio), .chan_is_pwm(chan_is_pwm), .pwm_pin(pwm_pin),
    .ram_collision(ram_collision), .svc_done(svc_done), .grant_valid(grant_valid),
    .grant_chan(grant_chan), .slot_prio(slot_prio), .nop_active(nop_active),
    .trans_active(trans_active), .stall_active(stall_active));

  chs_channel_model eng_u (.sys_clk(sys_clk), .reset_n(reset_n), .grant_valid(grant_valid),
    .grant_chan(grant_chan), .chan_is_pwm(chan_is_pwm), .svc_done(svc_done));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk

  task automatic note(input int c, input int l, input int n, input int s);
    q.push_back('{c, l, n, s});
  endtask : note

  // Drop level requests once every grant is seen, then wait for quiet
  task automatic wait_idle;
    for (t = 0; t < 3000; t++) begin
      @(negedge sys_clk);
      if (q.size() == 0) svc_req = '0;
      if (q.size() == 0 && grant_valid === 1'b0 && trans_active === 1'b0) break;
    end
    if (t == 3000) miscompares++;
  endtask : wait_idle

  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Watchdog cuts a hang short
  initial begin
    #(25 * 20000);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // Monitor: compare each grant with the oldest note, mid-cycle when settled
  // ----------------------------------------
  always @(negedge sys_clk) begin
    if (!reset_n) begin
      ing = 0;
      prev = 0;
    end else if (grant_valid === 1'b1) begin
      if (!ing) begin
        if (q.size() == 0) begin
          miscompares++;
          cur.len = 0;
          $display("mismatch grant_chan expected none seen %0d", grant_chan);
        end else begin
          cur = q.pop_front();
          chk("grant_chan", grant_chan, cur.chan);
          chk("slot_prio", slot_prio, chan_prio[2*cur.chan +: 2]);
          if (prev) chk("trans_cycles", trn, 10);
          if (prev && cur.nop >= 0) chk("nop_cycles", nops, cur.nop);
        end
        ing = 1;
        glen = 0;
        stl = 0;
      end
      glen++;
      stl += stall_active;
    end else begin
      if (ing && cur.len > 0) begin
        chk("grant_cycles", glen, cur.len);
        chk("stall_cycles", stl, cur.stall);
      end
      if (ing) begin
        trn = 0;
        nops = 0;
        prev = 1;
      end
      ing = 0;
      trn += trans_active;
      nops += nop_active;
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    rnd = 32'h9dc871ae;
    reset_n = 1'b0;
    ram_collision = 1'b0;
    svc_req = '0;
    pwm_pin = '0;
    chan_is_pwm = 16'h0001;
    chan_prio = 32'h00000def; // ch0,1,3,5 high, ch2 middle, ch4 low
    repeat (16) @(negedge sys_clk);
    // Slot pattern with one requester per level from slot 0
    foreach (pat[j]) note(pat[j], 0, -1, 0);
    svc_req = 16'h0016;
    reset_n = 1'b1;
    wait_idle();
    // Two high channels: ascending order, no-op only on a new round
    note(3, 0, -1, 0);
    note(5, 0, 0, 0);
    note(3, 0, 4, 0);
    note(5, 0, 0, 0);
    svc_req = 16'h0028;
    wait_idle();
    // Pulse-width edges, with one random collision on later rises
    for (i = 0; i < 3; i++) begin
      note(0, (i > 0) ? 26 : 24, -1, (i > 0) ? 2 : 0);
      pwm_pin[0] = 1'b1;
      if (i > 0) begin
        rnd = lfsr(rnd);
        k = 1 + rnd[3:0];
        for (t = 0; t < 100 && grant_valid !== 1'b1; t++) @(negedge sys_clk);
        if (t == 100) miscompares++;
        repeat (k) @(negedge sys_clk);
        ram_collision = 1'b1;
        @(negedge sys_clk);
        ram_collision = 1'b0;
      end
      wait_idle();
      note(0, 2, -1, 0);
      pwm_pin[0] = 1'b0;
      wait_idle();
    end
    finish_test();
  end
endmodule : chs_scheduler_tb_top
